/* File: design/timer_pkg.sv */
// Operation
// - Timer function adds one per machine cycle, rate oscillator over twelve; timer 2 in baud mode runs at oscillator over two.
// - Counter function adds one per sampled falling edge on its count pin.
// - Edge detection spans two machine cycles; source stays below oscillator over 24.
// - Each gate pin may gate its timer for pulse width measurement.
// - Timer 2 is sixteen bits, timer or counter by control bit one.
// - Plain auto-reload mode reloads timer 2 from reload/capture on overflow.
// - Auto-reload with trigger enable also reloads on trigger pin falling edge.
// - Down-count enable: trigger pin low counts down, high counts up.
// - Capture mode runs timer 2 as sixteen-bit up-only counter.
// - Capture mode trigger edge copies count into reload/capture bytes.
// - Either serial clock select makes baud generator without overflow flag.
// - Baud mode trigger edge raises the timer 2 external flag.
// - Timers 0 and 1 mode 0 is 8-bit count after divide-by-32.
// - Mode 1 is sixteen-bit, mode 2 is 8-bit with 8-bit reload.
`default_nettype none
package timer_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam logic [3:0]  MC_LAST       = 4'hb;
  localparam logic [4:0]  DIV16_LAST    = 5'h0f;
  localparam logic [4:0]  DIV32_LAST    = 5'h1f;

  localparam logic [7:0]  OFF_TMOD      = 8'h00;
  localparam logic [7:0]  OFF_RUN       = 8'h04;
  localparam logic [7:0]  OFF_T0        = 8'h08;
  localparam logic [7:0]  OFF_T1        = 8'h0c;
  localparam logic [7:0]  OFF_T2CTL     = 8'h10;
  localparam logic [7:0]  OFF_TIMER2_MODE_REG     = 8'h14;
  localparam logic [7:0]  OFF_RCAP      = 8'h18;
  localparam logic [7:0]  OFF_T2        = 8'h1c;
  localparam logic [7:0]  OFF_ISTAT     = 8'h20;
  localparam logic [7:0]  OFF_ICLR      = 8'h24;
  localparam logic [7:0]  OFF_IEN       = 8'h28;

  // Mode field bits of each timer nibble
  localparam int unsigned TM_CT         = 2;
  localparam int unsigned TM_GATE       = 3;
  localparam logic [1:0]  MODE_13BIT    = 2'h0;
  localparam logic [1:0]  MODE_16BIT    = 2'h1;
  localparam logic [1:0]  MODE_RELOAD   = 2'h2;
  localparam logic [1:0]  MODE_SPLIT    = 2'h3;

  localparam int unsigned RUN_T0        = 0;
  localparam int unsigned RUN_T1        = 1;
  localparam int unsigned RUN_BAUD_DOUBLING_BIT      = 2;

  // Timer 2 control bits; flags 7 and 6 read from status
  localparam int unsigned T2C_CPRL      = 0;
  localparam int unsigned T2C_CT        = 1;
  localparam int unsigned T2C_RUN       = 2;
  localparam int unsigned T2C_EXEN      = 3;
  localparam int unsigned T2C_TX_CLOCK_FROM_TIMER_SEL      = 4;
  localparam int unsigned T2C_RCLK      = 5;

  localparam int unsigned IS_TF0        = 0;
  localparam int unsigned IS_TF1        = 1;
  localparam int unsigned IS_TF2        = 2;
  localparam int unsigned IS_TIMER2_EXTERNAL_FLAG       = 3;

  // Pin vector order
  localparam int unsigned PIN_T0        = 0;
  localparam int unsigned PIN_T1        = 1;
  localparam int unsigned PIN_G0        = 2;
  localparam int unsigned PIN_G1        = 3;
  localparam int unsigned PIN_T2        = 4;
  localparam int unsigned PIN_TRIG      = 5;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage
`default_nettype wire

/* File: design/pin_edge_sampler.sv */
`timescale 1ns/1ns
`default_nettype none
module pin_edge_sampler (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic pin,
  input  wire logic mc_tick,
  output logic      level,
  output logic      fall
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic samp;
    logic fall;
  } samp_s;

  samp_s s_reg;
  samp_s s_next;

  always_comb
  begin
    s_next = s_reg;
    s_next.sync1 = pin;
    s_next.sync2 = s_reg.sync1;
    s_next.fall = 1'b0;
    // One sample per machine cycle; a fall needs a high then a low sample
    if (mc_tick)
    begin
      s_next.samp = s_reg.sync2;
      s_next.fall = s_reg.samp & ~s_reg.sync2;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign level = s_reg.samp;
  assign fall = s_reg.fall;
endmodule
`default_nettype wire

/* File: design/timer_counter_units.sv */
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module timer_counter_units (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        timer0_count_pin,
  input  wire logic        timer1_count_pin,
  input  wire logic        gate_pin_zero,
  input  wire logic        gate_pin_one,
  input  wire logic        timer2_count_pin,
  input  wire logic        timer2_trigger_pin,
  output logic             irq,
  output logic             tx_rate_tick,
  output logic             rx_rate_tick
);
  typedef struct packed {
    logic [3:0]       mc_cnt;
    logic             mc_tick;
    logic             half_tick;
    logic [7:0]       tmod;
    logic [2:0]       run_ctrl;
    logic [1:0][15:0] tc;
    logic [5:0]       t2ctl;
    logic             down_count_enable;
    logic [15:0]      rcap;
    logic [15:0]      t2;
    logic [3:0]       ist;
    logic [3:0]       ien;
    logic [1:0][4:0]  rate_div;
    logic [1:0]       rate_tick;
    logic             irq;
    logic             aw_got;
    logic [7:0]       aw_addr;
    logic             w_got;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } state_s;

  state_s      s_reg;
  state_s      s_next;
  logic [5:0]  pin_vec;
  logic [5:0]  lvl;
  logic [5:0]  fall;
  logic [1:0]  ovf01;
  logic [16:0] step;
  logic [3:0]  fld;
  logic        ev;
  logic        baud;
  logic        ev2;
  logic        trig2;
  logic        t2_ovf;
  logic        t2_ext;
  logic        t2_baud_ovf;
  logic        do_wr;
  logic        sel2;
  logic        src;
  logic [4:0]  lim;
  logic [32:0] rd_res;
  logic [32:0] cur_res;
  logic [31:0] wmask;
  logic [31:0] wv;
  logic [3:0]  ist_clr;

  assign pin_vec = {timer2_trigger_pin, timer2_count_pin, gate_pin_one, gate_pin_zero,
                    timer1_count_pin, timer0_count_pin};

  generate
    for (genvar g = 0; g < 6; g++)
    begin : g_pin
      pin_edge_sampler u_samp (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .pin     (pin_vec[g]),
        .mc_tick (s_reg.mc_tick),
        .level   (lvl[g]),
        .fall    (fall[g])
      );
    end
  endgenerate

  // One count step of timer 0 or 1: {overflow, new value}
  function automatic logic [16:0] t01_step(input logic [1:0] m, input logic [15:0] v);
    logic [13:0] s13;
    logic [8:0]  lo;
    s13 = {1'b0, v[15:8], v[4:0]} + 14'h1;
    lo = {1'b0, v[7:0]} + 9'h1;
    unique case (m)
      timer_pkg::MODE_13BIT:  t01_step = {s13[13], s13[12:5], v[7:5], s13[4:0]};
      timer_pkg::MODE_16BIT:  t01_step = {1'b0, v} + 17'h1;
      timer_pkg::MODE_RELOAD: t01_step = {lo[8], v[15:8], lo[8] ? v[15:8] : lo[7:0]};
      timer_pkg::MODE_SPLIT:  t01_step = {1'b0, v};
    endcase
  endfunction

  // Register readback: {hit, data}
  function automatic logic [32:0] read_word(input state_s st, input logic [7:0] a);
    unique case (a)
      timer_pkg::OFF_TMOD:  read_word = {1'b1, 24'h0, st.tmod};
      timer_pkg::OFF_RUN:   read_word = {1'b1, 29'h0, st.run_ctrl};
      timer_pkg::OFF_T0:    read_word = {1'b1, 16'h0, st.tc[0]};
      timer_pkg::OFF_T1:    read_word = {1'b1, 16'h0, st.tc[1]};
      timer_pkg::OFF_T2CTL: read_word = {1'b1, 24'h0, st.ist[timer_pkg::IS_TF2],
                                         st.ist[timer_pkg::IS_TIMER2_EXTERNAL_FLAG], st.t2ctl};
      timer_pkg::OFF_TIMER2_MODE_REG: read_word = {1'b1, 31'h0, st.down_count_enable};
      timer_pkg::OFF_RCAP:  read_word = {1'b1, 16'h0, st.rcap};
      timer_pkg::OFF_T2:    read_word = {1'b1, 16'h0, st.t2};
      timer_pkg::OFF_ISTAT: read_word = {1'b1, 28'h0, st.ist};
      timer_pkg::OFF_ICLR:  read_word = {1'b1, 32'h0};
      timer_pkg::OFF_IEN:   read_word = {1'b1, 28'h0, st.ien};
      default:              read_word = {1'b0, 32'h0};
    endcase
  endfunction

  always_comb
  begin
    s_next = s_reg;
    ovf01 = 2'h0;
    step = 17'h0;
    fld = 4'h0;
    ev = 1'b0;
    t2_ovf = 1'b0;
    t2_ext = 1'b0;
    t2_baud_ovf = 1'b0;
    sel2 = 1'b0;
    src = 1'b0;
    lim = timer_pkg::DIV32_LAST;
    ist_clr = 4'h0;
    s_next.rate_tick = 2'h0;

    // Machine cycle: one tick per twelve oscillator clocks
    s_next.mc_tick = 1'b0;
    if (s_reg.mc_cnt == timer_pkg::MC_LAST)
    begin
      s_next.mc_cnt = 4'h0;
      s_next.mc_tick = 1'b1;
    end
    else
      s_next.mc_cnt = s_reg.mc_cnt + 4'h1;
    s_next.half_tick = ~s_reg.half_tick;

    // Timers 0 and 1
    for (int i = 0; i < 2; i++)
    begin
      fld = s_reg.tmod[4*i +: 4];
      ev = fld[timer_pkg::TM_CT] ? fall[timer_pkg::PIN_T0 + i] : s_reg.mc_tick;
      if (s_reg.run_ctrl[i] && (!fld[timer_pkg::TM_GATE] || lvl[timer_pkg::PIN_G0 + i]) && ev)
      begin
        step = t01_step(fld[1:0], s_reg.tc[i]);
        s_next.tc[i] = step[15:0];
        ovf01[i] = step[16];
      end
    end

    // Timer 2
    baud = s_reg.t2ctl[timer_pkg::T2C_RCLK] | s_reg.t2ctl[timer_pkg::T2C_TX_CLOCK_FROM_TIMER_SEL];
    ev2 = s_reg.t2ctl[timer_pkg::T2C_CT] ? fall[timer_pkg::PIN_T2] :
          (baud ? s_reg.half_tick : s_reg.mc_tick);
    trig2 = s_reg.t2ctl[timer_pkg::T2C_EXEN] & fall[timer_pkg::PIN_TRIG];
    if (s_reg.t2ctl[timer_pkg::T2C_RUN])
    begin
      if (baud)
      begin
        if (ev2)
        begin
          if (&s_reg.t2)
          begin
            s_next.t2 = s_reg.rcap;
            t2_baud_ovf = 1'b1;
          end
          else
            s_next.t2 = s_reg.t2 + 16'h1;
        end
        t2_ext = trig2;
      end
      else if (s_reg.t2ctl[timer_pkg::T2C_CPRL])
      begin
        if (ev2)
        begin
          t2_ovf = &s_reg.t2;
          s_next.t2 = s_reg.t2 + 16'h1;
        end
        if (trig2)
        begin
          s_next.rcap = s_reg.t2;
          t2_ext = 1'b1;
        end
      end
      else if (s_reg.down_count_enable)
      begin
        if (ev2 && lvl[timer_pkg::PIN_TRIG])
        begin
          t2_ovf = &s_reg.t2;
          s_next.t2 = t2_ovf ? s_reg.rcap : s_reg.t2 + 16'h1;
        end
        else if (ev2)
        begin
          t2_ovf = (s_reg.t2 == s_reg.rcap);
          s_next.t2 = t2_ovf ? 16'hffff : s_reg.t2 - 16'h1;
        end
      end
      else
      begin
        if (ev2)
        begin
          t2_ovf = &s_reg.t2;
          s_next.t2 = t2_ovf ? s_reg.rcap : s_reg.t2 + 16'h1;
        end
        if (trig2)
        begin
          s_next.t2 = s_reg.rcap;
          t2_ext = 1'b1;
        end
      end
    end

    // Serial rate ticks: index 0 transmit, 1 receive
    for (int j = 0; j < 2; j++)
    begin
      sel2 = (j == 0) ? s_reg.t2ctl[timer_pkg::T2C_TX_CLOCK_FROM_TIMER_SEL] : s_reg.t2ctl[timer_pkg::T2C_RCLK];
      src = sel2 ? t2_baud_ovf : ovf01[1];
      lim = (sel2 || s_reg.run_ctrl[timer_pkg::RUN_BAUD_DOUBLING_BIT]) ? timer_pkg::DIV16_LAST :
            timer_pkg::DIV32_LAST;
      if (src)
      begin
        if (s_reg.rate_div[j] >= lim)
        begin
          s_next.rate_div[j] = 5'h0;
          s_next.rate_tick[j] = 1'b1;
        end
        else
          s_next.rate_div[j] = s_reg.rate_div[j] + 5'h1;
      end
    end

    // Bus write channel
    if (s_reg.bvalid && bready)
      s_next.bvalid = 1'b0;
    if (awvalid && s_reg.awready)
    begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = awaddr;
      s_next.awready = 1'b0;
    end
    if (wvalid && s_reg.wready)
    begin
      s_next.w_got = 1'b1;
      s_next.w_data = wdata;
      s_next.w_strb = wstrb;
      s_next.wready = 1'b0;
    end
    do_wr = s_reg.aw_got & s_reg.w_got & ~s_reg.bvalid;
    cur_res = read_word(s_reg, s_reg.aw_addr);
    wmask = {{8{s_reg.w_strb[3]}}, {8{s_reg.w_strb[2]}}, {8{s_reg.w_strb[1]}},
             {8{s_reg.w_strb[0]}}};
    wv = (cur_res[31:0] & ~wmask) | (s_reg.w_data & wmask);
    if (do_wr)
    begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.awready = 1'b1;
      s_next.wready = 1'b1;
      s_next.bvalid = 1'b1;
      s_next.bresp = cur_res[32] ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      unique case (s_reg.aw_addr)
        timer_pkg::OFF_TMOD:  s_next.tmod = wv[7:0];
        timer_pkg::OFF_RUN:   s_next.run_ctrl = wv[2:0];
        timer_pkg::OFF_T0:    s_next.tc[0] = wv[15:0];
        timer_pkg::OFF_T1:    s_next.tc[1] = wv[15:0];
        timer_pkg::OFF_T2CTL: s_next.t2ctl = wv[5:0];
        timer_pkg::OFF_TIMER2_MODE_REG: s_next.down_count_enable = wv[0];
        timer_pkg::OFF_RCAP:  s_next.rcap = wv[15:0];
        timer_pkg::OFF_T2:    s_next.t2 = wv[15:0];
        timer_pkg::OFF_ICLR:  ist_clr = s_reg.w_data[3:0] & {4{s_reg.w_strb[0]}};
        timer_pkg::OFF_IEN:   s_next.ien = wv[3:0];
        default:              ist_clr = 4'h0;
      endcase
    end

    // Sticky flags; a new event beats a clear in the same cycle
    s_next.ist = (s_reg.ist & ~ist_clr) | {t2_ext, t2_ovf, ovf01};
    s_next.irq = |(s_next.ist & s_next.ien);

    // Bus read channel
    rd_res = read_word(s_reg, araddr);
    if (s_reg.rvalid && rready)
    begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end
    if (arvalid && s_reg.arready)
    begin
      s_next.arready = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_res[31:0];
      s_next.rresp = rd_res[32] ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      s_reg <= '0;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  assign awready = s_reg.awready;
  assign wready = s_reg.wready;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign arready = s_reg.arready;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign irq = s_reg.irq;
  assign tx_rate_tick = s_reg.rate_tick[0];
  assign rx_rate_tick = s_reg.rate_tick[1];

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_mc_tick_period: assert property (s_reg.mc_tick |-> ##12 s_reg.mc_tick)
    else $error("machine cycle tick not every twelve clocks");
  a_t0_timer_inc: assert property ((s_reg.mc_tick && s_reg.run_ctrl[0]
    && s_reg.tmod[3:0] == 4'h1 && !do_wr) |=> s_reg.tc[0] == $past(s_reg.tc[0]) + 16'h1)
    else $error("timer 0 did not step on machine cycle");
  a_t1_edge_count: assert property ((fall[1] && s_reg.run_ctrl[1]
    && s_reg.tmod[7:4] == 4'h5 && !do_wr) |=> s_reg.tc[1] == $past(s_reg.tc[1]) + 16'h1)
    else $error("timer 1 missed a count pin edge");
  a_edge_on_sample: assert property (fall[0] |-> $past(s_reg.mc_tick))
    else $error("edge reported outside machine cycle sample");
  a_gate_holds: assert property ((s_reg.tmod[3] && !lvl[2] && !do_wr)
    |=> $stable(s_reg.tc[0]))
    else $error("gated timer 0 moved");
  a_t2_stop_hold: assert property ((!s_reg.t2ctl[2] && !do_wr) |=> $stable(s_reg.t2))
    else $error("timer 2 moved while stopped");
  a_t2_reload_ovf: assert property ((s_reg.t2ctl == 6'h04 && !s_reg.down_count_enable && ev2
    && &s_reg.t2 && !trig2 && !do_wr)
    |=> s_reg.t2 == $past(s_reg.rcap) && s_reg.ist[2])
    else $error("timer 2 reload or overflow flag wrong");
  a_t2_count_down: assert property ((s_reg.t2ctl[2] && !baud && !s_reg.t2ctl[0] && s_reg.down_count_enable && ev2
    && !lvl[5] && s_reg.t2 != s_reg.rcap && !do_wr)
    |=> s_reg.t2 == $past(s_reg.t2) - 16'h1)
    else $error("timer 2 did not count down");
  a_t2_capture: assert property ((s_reg.t2ctl[2] && s_reg.t2ctl[0] && !baud && trig2
    && !do_wr) |=> s_reg.rcap == $past(s_reg.t2) && s_reg.ist[3])
    else $error("timer 2 capture failed");
  a_baud_no_flag: assert property ((s_reg.t2ctl[2] && baud && !s_reg.ist[2])
    |=> !s_reg.ist[2])
    else $error("overflow flag set in baud generator mode");
endmodule
`default_nettype wire

/* File: testbench/pin_model.sv */
`timescale 1ns/1ns
`default_nettype none
module pin_model (
  input  wire logic ref_clk,
  output logic      timer0_count_pin,
  output logic      timer1_count_pin,
  output logic      gate_pin_zero,
  output logic      gate_pin_one,
  output logic      timer2_count_pin,
  output logic      timer2_trigger_pin
);
  // Port pins idle high through their pull-ups
  logic [5:0] lvl = 6'h3f;

  assign timer0_count_pin   = lvl[timer_pkg::PIN_T0];
  assign timer1_count_pin   = lvl[timer_pkg::PIN_T1];
  assign gate_pin_zero      = lvl[timer_pkg::PIN_G0];
  assign gate_pin_one       = lvl[timer_pkg::PIN_G1];
  assign timer2_count_pin   = lvl[timer_pkg::PIN_T2];
  assign timer2_trigger_pin = lvl[timer_pkg::PIN_TRIG];

  task automatic set_pin(input int idx, input logic v);
    @(posedge ref_clk);
    lvl[idx] <= v;
  endtask

  // Each level held two machine cycles
  task automatic falls(input int idx, input int n);
    repeat (n)
    begin
      set_pin(idx, 1'b0);
      repeat (24) @(posedge ref_clk);
      set_pin(idx, 1'b1);
      repeat (24) @(posedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire

/* File: testbench/timer_counter_units_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module timer_counter_units_bench;
  logic        ref_clk = 1'b0;
  logic        rstn    = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, tx_rate_tick, rx_rate_tick;
  logic        timer0_count_pin, timer1_count_pin, gate_pin_zero, gate_pin_one;
  logic        timer2_count_pin, timer2_trigger_pin;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] rdata, rv, t2v;
  int          error_cnt   = 0;
  int          checks_done = 0;
  int          tx_cnt      = 0;
  int          rx_cnt      = 0;

  timer_counter_units timer_counter_units_i (
    .ref_clk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .timer0_count_pin, .timer1_count_pin, .gate_pin_zero, .gate_pin_one, .timer2_count_pin,
    .timer2_trigger_pin, .irq, .tx_rate_tick, .rx_rate_tick
  );

  pin_model pin_model_i (
    .ref_clk, .timer0_count_pin, .timer1_count_pin, .gate_pin_zero, .gate_pin_one,
    .timer2_count_pin, .timer2_trigger_pin
  );

  always #25 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
  begin
    if (tx_rate_tick === 1'b1) tx_cnt++;
    if (rx_rate_tick === 1'b1) rx_cnt++;
  end

  task automatic complete_run;
    $display("Mismatches %0d, comparisons %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic hang;
    error_cnt++;
    $display("Error at %0t: wait limit reached", $time);
    complete_run();
  endtask

  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ck_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checks_done++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      error_cnt++;
      $display("Error at %0t: got %h outside %h to %h", $time, got, lo, hi);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 100);
    rsp = bresp;
    bready <= 1'b0;
    if (n >= 100) hang();
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 100);
    rv = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (n >= 100) hang();
    @(posedge ref_clk);
  endtask

  task automatic s_reset;
    rd(timer_pkg::OFF_TMOD);
    ck(rv, 32'h0);
    rd(timer_pkg::OFF_T2);
    ck(rv, 32'h0);
    rd(8'h2c);
    ck({30'h0, rsp}, {30'h0, timer_pkg::RESP_SLVERR});
    ck(rv, 32'h0);
    wr(8'h02, 32'h0);
    ck({30'h0, rsp}, {30'h0, timer_pkg::RESP_SLVERR});
    ck({31'h0, irq}, 32'h0);
  endtask

  task automatic s_timer0;
    wr(timer_pkg::OFF_TMOD, 32'h1);
    wr(timer_pkg::OFF_T0, 32'h0);
    wr(timer_pkg::OFF_RUN, 32'h1);
    idle(1200);
    wr(timer_pkg::OFF_RUN, 32'h0);
    rd(timer_pkg::OFF_T0);
    ck_rng(rv, 32'd98, 32'd102);
    wr(timer_pkg::OFF_TMOD, 32'h0);
    wr(timer_pkg::OFF_T0, 32'h0);
    wr(timer_pkg::OFF_RUN, 32'h1);
    idle(1200);
    wr(timer_pkg::OFF_RUN, 32'h0);
    rd(timer_pkg::OFF_T0);
    ck({24'h0, rv[15:8]}, 32'h3);
  endtask

  task automatic s_gate;
    wr(timer_pkg::OFF_TMOD, 32'h9);
    wr(timer_pkg::OFF_T0, 32'h0);
    pin_model_i.set_pin(timer_pkg::PIN_G0, 1'b0);
    idle(40);
    wr(timer_pkg::OFF_RUN, 32'h1);
    idle(600);
    rd(timer_pkg::OFF_T0);
    ck(rv, 32'h0);
    pin_model_i.set_pin(timer_pkg::PIN_G0, 1'b1);
    idle(600);
    wr(timer_pkg::OFF_RUN, 32'h0);
    rd(timer_pkg::OFF_T0);
    ck_rng(rv, 32'd45, 32'd52);
  endtask

  task automatic s_timer1;
    int c;
    wr(timer_pkg::OFF_TMOD, 32'h50);
    wr(timer_pkg::OFF_T1, 32'h0);
    wr(timer_pkg::OFF_RUN, 32'h2);
    pin_model_i.falls(timer_pkg::PIN_T1, 7);
    idle(40);
    rd(timer_pkg::OFF_T1);
    ck(rv, 32'h7);
    wr(timer_pkg::OFF_TMOD, 32'h20);
    wr(timer_pkg::OFF_T1, 32'hffff);
    wr(timer_pkg::OFF_RUN, 32'h6);
    idle(64);
    c = rx_cnt;
    idle(1920);
    ck_rng(rx_cnt - c, 32'd9, 32'd11);
    wr(timer_pkg::OFF_RUN, 32'h0);
    rd(timer_pkg::OFF_T1);
    ck(rv, 32'hffff);
    rd(timer_pkg::OFF_ISTAT);
    ck(rv & 32'h2, 32'h2);
  endtask

  task automatic s_t2_reload;
    wr(timer_pkg::OFF_ICLR, 32'hf);
    wr(timer_pkg::OFF_IEN, 32'h4);
    wr(timer_pkg::OFF_RCAP, 32'hff00);
    wr(timer_pkg::OFF_T2, 32'hff00);
    wr(timer_pkg::OFF_T2CTL, 32'h4);
    idle(3300);
    wr(timer_pkg::OFF_T2CTL, 32'h0);
    rd(timer_pkg::OFF_T2);
    ck_rng(rv, 32'hff00, 32'hff30);
    ck({31'h0, irq}, 32'h1);
    wr(timer_pkg::OFF_IEN, 32'h0);
    rd(timer_pkg::OFF_ISTAT);
    ck(rv & 32'h4, 32'h4);
    ck({31'h0, irq}, 32'h0);
    wr(timer_pkg::OFF_ICLR, 32'h4);
    rd(timer_pkg::OFF_ISTAT);
    ck(rv & 32'h4, 32'h0);
    wr(timer_pkg::OFF_T2, 32'h0);
    wr(timer_pkg::OFF_T2CTL, 32'h6);
    pin_model_i.falls(timer_pkg::PIN_T2, 4);
    idle(40);
    wr(timer_pkg::OFF_T2CTL, 32'h0);
    rd(timer_pkg::OFF_T2);
    ck(rv, 32'h4);
  endtask

  task automatic s_t2_trigger;
    wr(timer_pkg::OFF_ICLR, 32'hf);
    wr(timer_pkg::OFF_RCAP, 32'h1000);
    wr(timer_pkg::OFF_T2, 32'h8000);
    wr(timer_pkg::OFF_T2CTL, 32'hc);
    pin_model_i.falls(timer_pkg::PIN_TRIG, 1);
    wr(timer_pkg::OFF_T2CTL, 32'h0);
    rd(timer_pkg::OFF_T2);
    ck_rng(rv, 32'h1000, 32'h1008);
    rd(timer_pkg::OFF_ISTAT);
    ck(rv & 32'hc, 32'h8);
  endtask

  task automatic s_t2_down;
    wr(timer_pkg::OFF_TIMER2_MODE_REG, 32'h1);
    wr(timer_pkg::OFF_RCAP, 32'h0);
    wr(timer_pkg::OFF_T2, 32'h5000);
    pin_model_i.set_pin(timer_pkg::PIN_TRIG, 1'b0);
    idle(40);
    wr(timer_pkg::OFF_T2CTL, 32'hc);
    idle(1200);
    wr(timer_pkg::OFF_T2CTL, 32'h0);
    rd(timer_pkg::OFF_T2);
    ck_rng(rv, 32'h4f98, 32'h4fa0);
    pin_model_i.set_pin(timer_pkg::PIN_TRIG, 1'b1);
    wr(timer_pkg::OFF_TIMER2_MODE_REG, 32'h0);
  endtask

  task automatic s_t2_capture;
    wr(timer_pkg::OFF_ICLR, 32'hf);
    wr(timer_pkg::OFF_RCAP, 32'h0);
    wr(timer_pkg::OFF_T2, 32'hfff0);
    wr(timer_pkg::OFF_T2CTL, 32'hd);
    idle(384);
    pin_model_i.falls(timer_pkg::PIN_TRIG, 1);
    wr(timer_pkg::OFF_T2CTL, 32'h0);
    rd(timer_pkg::OFF_T2);
    t2v = rv;
    ck_rng(rv, 32'h10, 32'h30);
    rd(timer_pkg::OFF_RCAP);
    ck_rng(rv, t2v - 32'd8, t2v);
    rd(timer_pkg::OFF_ISTAT);
    ck(rv & 32'hc, 32'hc);
  endtask

  task automatic s_t2_baud;
    int c;
    wr(timer_pkg::OFF_ICLR, 32'hf);
    wr(timer_pkg::OFF_RCAP, 32'hfffe);
    wr(timer_pkg::OFF_T2, 32'hfffe);
    wr(timer_pkg::OFF_T2CTL, 32'h1c);
    idle(64);
    c = tx_cnt;
    idle(640);
    ck_rng(tx_cnt - c, 32'd9, 32'd11);
    pin_model_i.falls(timer_pkg::PIN_TRIG, 1);
    wr(timer_pkg::OFF_T2CTL, 32'h0);
    rd(timer_pkg::OFF_ISTAT);
    ck(rv & 32'hc, 32'h8);
    wr(timer_pkg::OFF_T2, 32'h1234);
    wr(timer_pkg::OFF_T2CTL, 32'h3);
    pin_model_i.falls(timer_pkg::PIN_T2, 2);
    rd(timer_pkg::OFF_T2);
    ck(rv, 32'h1234);
  endtask

  initial #5000000 hang();

  initial
  begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    s_reset();
    s_timer0();
    s_gate();
    s_timer1();
    s_t2_reload();
    s_t2_trigger();
    s_t2_down();
    s_t2_capture();
    s_t2_baud();
    complete_run();
  end
endmodule
`default_nettype wire
